/* inc/calc_if.sv */
`timescale 1ns/1ps
interface calc_if;
  logic [63:0] candidatePwd;
  logic [63:0] storedPwd;
  logic        pwdGrant;
  logic [63:0] page2Old;
  logic [47:0] sig;
  logic [63:0] page2New;
  logic        atLimit;

  modport exec (output candidatePwd, storedPwd, page2Old, sig,
                input  pwdGrant, page2New, atLimit);
  modport pwdUnit (input candidatePwd, storedPwd, output pwdGrant);
  modport cntUnit (input page2Old, sig, output page2New, atLimit);
endinterface

/* inc/tag_cmd_pkg.sv */
package tag_cmd_pkg;

  // opcodes in the high nibble of the first frame byte
  localparam logic [3:0] OP_VERIFY   = 4'h6;
  localparam logic [3:0] OP_HALT_REL = 4'hA;
  localparam logic [3:0] OP_COUNT    = 4'hE;
  localparam logic [3:0] OP_LOCK     = 4'h2;

  // reply second byte: low nibble ack/nack, high nibble error code
  localparam logic [3:0] ACK_NIB      = 4'h0;
  localparam logic [3:0] NACK_NIB     = 4'h1;
  localparam logic [3:0] ERR_NONE     = 4'h0;
  localparam logic [3:0] ERR_LOCKED   = 4'h1;
  localparam logic [3:0] ERR_LIMIT    = 4'h2;
  localparam logic [3:0] ERR_PASSWORD = 4'h4;

  // frame layout, bytes sent least significant first
  localparam int FRAME_BITS    = 96;
  localparam int CMD_DATA_LSB  = 16;
  localparam int LOCK_DATA_LSB = 32;
  localparam int SIG_BITS      = 48;

  // page numbers and fields inside a 64-bit page
  localparam logic [4:0] PAGE_SERIAL   = 5'h00;
  localparam logic [4:0] PAGE_COUNTER  = 5'h02;
  localparam logic [4:0] PAGE_PASSWORD = 5'h03;
  localparam int LOCK_MASK_LSB = 32;
  localparam int COUNTER_LSB   = 48;

  localparam logic [15:0] COUNTER_LIMIT   = 16'h8000;
  localparam logic [15:0] COUNTER_STEP    = 16'h0001;
  localparam logic [63:0] PWD_ALL_ONES    = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [31:0] LOCK_USABLE     = 32'hFFFF_FFFE;

  // values after reset
  localparam logic RESET_OPEN   = 1'b0;
  localparam logic RESET_ACTIVE = 1'b0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RD_LOCKS,
    ST_RD_PAGE,
    ST_WRITE
  } state_type;

endpackage

/* src/count_calc.sv */
`timescale 1ns/1ps
module count_calc
  import tag_cmd_pkg::*;
(
  calc_if.cntUnit calc
);

  logic [15:0] countOld;

  assign countOld = calc.page2Old[COUNTER_LSB +: 16];

  // new page 2: reader bytes untouched below, incremented count above
  assign calc.page2New = {countOld + COUNTER_STEP, calc.sig};
  assign calc.atLimit  = (countOld == COUNTER_LIMIT);

endmodule

/* src/pwd_check.sv */
`timescale 1ns/1ps
module pwd_check
  import tag_cmd_pkg::*;
(
  calc_if.pwdUnit calc
);

  // full-width compare; an all-ones candidate never grants, so an all-ones
  // stored page can never be matched either; zero is an ordinary value
  assign calc.pwdGrant = (calc.candidatePwd == calc.storedPwd)
                         && (calc.candidatePwd != PWD_ALL_ONES);

endmodule

/* src/tag_cmd_exec.sv */
`timescale 1ns/1ps
// How it works
// - bit zero of lock mask ignored
// - locking page zero just acknowledges when access open
// - matching 64-bit password acknowledges and opens access
// - wrong password gets negative acknowledge
// - access stays open until reset or failure
// - password rewrite keeps access open
// - all-ones password always refused
// - stored all-ones password never grants access
// - delivered password zero, reader should change
// - halt-release acknowledges, enters halt state
// - halt-release never negatively acknowledged
// - six reader bytes stored, two dropped
// - counter increments by one per update
// - counter at 0x8000 blocks further updates
// - counter update needs open access
// - device writes new count after signature
// - refused updates nack, success acks after write
// - twelve-byte frames, opcode in high nibble
// - two-byte replies, low nibble ack/nack
// - set lock bit blocks page writes
module tag_cmd_exec
  import tag_cmd_pkg::*;
(
  // clock, reset, enable
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  clkEn,
  // checked command frame from the framing layer
  input  wire logic                  cmdValid,
  input  wire logic [FRAME_BITS-1:0] cmdFrame,
  // anticollision puts the tag into the active state
  input  wire logic                  wakeActive,
  // nonvolatile page memory
  output logic                       memReq,
  output logic                       memWrite,
  output logic [4:0]                 memPage,
  output logic [63:0]                memWrData,
  input  wire logic [63:0]           memRdData,
  input  wire logic                  memDone,
  // reply to the framing layer
  output logic                       replyValid,
  output logic [7:0]                 replyByte0,
  output logic [7:0]                 replyByte1,
  // status
  output logic                       accessOpen,
  output logic                       tagActive
);

  calc_if calc ();

  state_type   state_q;
  state_type   state_d;
  logic [3:0]  opcode_q;
  logic [3:0]  cid_q;
  logic [63:0] cmdData_q;
  logic        memReq_q;
  logic        memWrite_q;
  logic [4:0]  memPage_q;
  logic [63:0] memWrData_q;
  logic        replyValid_q;
  logic [7:0]  replyByte0_q;
  logic [7:0]  replyByte1_q;
  logic        accessOpen_q;
  logic        tagActive_q;

  logic [3:0]  cmdOp;
  logic        cmdTake;
  logic [31:0] idleLockReq;
  logic        replyGo;
  logic        replyNack;
  logic [3:0]  replyErr;
  logic        memGo;
  logic        memWrGo;
  logic [4:0]  memPage_d;
  logic [63:0] memWrData_d;
  logic        openSet;
  logic        openClr;
  logic        haltGo;
  logic [7:0]  replyHead;
  logic [15:0] cntOld;

  // usable lock bits of a request; page 0 can never be locked
  function automatic logic [31:0] page_lock_mask(input logic [31:0] req);
    page_lock_mask = req & LOCK_USABLE;
  endfunction

  pwd_check uPwd
  (
    .calc (calc.pwdUnit)
  );

  count_calc uCnt
  (
    .calc (calc.cntUnit)
  );

  // the password page and page 2 are checked as they come out of memory,
  // so a password rewritten by the generic write path is used at once
  assign calc.candidatePwd = cmdData_q;
  assign calc.storedPwd    = memRdData;
  assign calc.page2Old     = memRdData;
  assign calc.sig          = cmdData_q[SIG_BITS-1:0];

  // frame decode: CID low nibble, opcode high nibble
  assign cmdOp       = cmdFrame[7:4];
  assign cmdTake     = cmdValid && tagActive_q && (state_q == ST_IDLE);
  assign idleLockReq = page_lock_mask(cmdFrame[CMD_DATA_LSB+LOCK_DATA_LSB +: 32]);
  assign cntOld      = memRdData[COUNTER_LSB +: 16];

  // sequencing: decide replies, memory accesses and access changes
  always_comb
  begin
    state_d     = state_q;
    replyGo     = 1'b0;
    replyNack   = 1'b0;
    replyErr    = ERR_NONE;
    memGo       = 1'b0;
    memWrGo     = 1'b0;
    memPage_d   = memPage_q;
    memWrData_d = memWrData_q;
    openSet     = 1'b0;
    openClr     = 1'b0;
    haltGo      = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        if (cmdTake)
        begin
          case (cmdOp)
            OP_VERIFY:
            begin
              memGo     = 1'b1;
              memPage_d = PAGE_PASSWORD;
              state_d   = ST_RD_PAGE;
            end
            OP_HALT_REL:
            begin
              replyGo = 1'b1;
              haltGo  = 1'b1;
            end
            OP_COUNT:
            begin
              if (!accessOpen_q)
              begin
                replyGo   = 1'b1;
                replyNack = 1'b1;
                replyErr  = ERR_PASSWORD;
              end
              else
              begin
                memGo     = 1'b1;
                memPage_d = PAGE_SERIAL;
                state_d   = ST_RD_LOCKS;
              end
            end
            OP_LOCK:
            begin
              if (!accessOpen_q)
              begin
                replyGo   = 1'b1;
                replyNack = 1'b1;
                replyErr  = ERR_PASSWORD;
              end
              else if (idleLockReq == 32'h0000_0000)
              begin
                replyGo = 1'b1;
              end
              else
              begin
                memGo     = 1'b1;
                memPage_d = PAGE_SERIAL;
                state_d   = ST_RD_LOCKS;
              end
            end
            default:
            begin
              // other opcodes belong to the generic datapath
              state_d = ST_IDLE;
            end
          endcase
        end
      end
      ST_RD_LOCKS:
      begin
        if (memDone)
        begin
          if (opcode_q == OP_LOCK)
          begin
            // merge, never clear: a lock can not be undone
            memGo       = 1'b1;
            memWrGo     = 1'b1;
            memPage_d   = PAGE_SERIAL;
            memWrData_d = memRdData
                          | {page_lock_mask(cmdData_q[LOCK_DATA_LSB +: 32]), 32'h0000_0000};
            state_d     = ST_WRITE;
          end
          else if (memRdData[LOCK_MASK_LSB + int'(PAGE_COUNTER)])
          begin
            replyGo   = 1'b1;
            replyNack = 1'b1;
            replyErr  = ERR_LOCKED;
            state_d   = ST_IDLE;
          end
          else
          begin
            memGo     = 1'b1;
            memPage_d = PAGE_COUNTER;
            state_d   = ST_RD_PAGE;
          end
        end
      end
      ST_RD_PAGE:
      begin
        if (memDone)
        begin
          if (opcode_q == OP_VERIFY)
          begin
            replyGo = 1'b1;
            state_d = ST_IDLE;
            if (calc.pwdGrant)
            begin
              openSet = 1'b1;
            end
            else
            begin
              replyNack = 1'b1;
              replyErr  = ERR_PASSWORD;
              openClr   = 1'b1;
            end
          end
          else if (calc.atLimit)
          begin
            replyGo   = 1'b1;
            replyNack = 1'b1;
            replyErr  = ERR_LIMIT;
            state_d   = ST_IDLE;
          end
          else
          begin
            memGo       = 1'b1;
            memWrGo     = 1'b1;
            memPage_d   = PAGE_COUNTER;
            memWrData_d = calc.page2New;
            state_d     = ST_WRITE;
          end
        end
      end
      ST_WRITE:
      begin
        if (memDone)
        begin
          replyGo = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // state and latched command; new frames are ignored while busy
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q   <= ST_IDLE;
      opcode_q  <= 4'h0;
      cid_q     <= 4'h0;
      cmdData_q <= 64'h0000_0000_0000_0000;
    end
    else if (clkEn)
    begin
      state_q <= state_d;
      if (cmdTake)
      begin
        opcode_q  <= cmdOp;
        cid_q     <= cmdFrame[3:0];
        cmdData_q <= cmdFrame[CMD_DATA_LSB +: 64];
      end
    end
  end

  // memory request is a one-cycle pulse; address and data hold until done
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      memReq_q    <= 1'b0;
      memWrite_q  <= 1'b0;
      memPage_q   <= PAGE_SERIAL;
      memWrData_q <= 64'h0000_0000_0000_0000;
    end
    else if (clkEn)
    begin
      memReq_q    <= memGo;
      memPage_q   <= memPage_d;
      memWrData_q <= memWrData_d;
      if (memGo)
      begin
        memWrite_q <= memWrGo;
      end
    end
  end

  // reply head echoes CID and opcode of the command being answered
  assign replyHead = (state_q == ST_IDLE) ? cmdFrame[7:0] : {opcode_q, cid_q};

  // reply pulse with second byte {error code, ack/nack}
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      replyValid_q <= 1'b0;
      replyByte0_q <= 8'h00;
      replyByte1_q <= 8'h00;
    end
    else if (clkEn)
    begin
      replyValid_q <= replyGo;
      if (replyGo)
      begin
        replyByte0_q <= replyHead;
        replyByte1_q <= {replyErr, replyNack ? NACK_NIB : ACK_NIB};
      end
    end
  end

  // access-open flag; page writes never touch it, only password checks do: a match sets it, a failure clears it
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      accessOpen_q <= RESET_OPEN;
    end
    else if (clkEn)
    begin
      if (openSet)
      begin
        accessOpen_q <= 1'b1;
      end
      else if (openClr)
      begin
        accessOpen_q <= 1'b0;
      end
    end
  end

  // active/halt; halt wins since a wake in the same cycle is stale
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tagActive_q <= RESET_ACTIVE;
    end
    else if (clkEn)
    begin
      if (haltGo)
      begin
        tagActive_q <= 1'b0;
      end
      else if (wakeActive)
      begin
        tagActive_q <= 1'b1;
      end
    end
  end

  assign memReq     = memReq_q;
  assign memWrite   = memWrite_q;
  assign memPage    = memPage_q;
  assign memWrData  = memWrData_q;
  assign replyValid = replyValid_q;
  assign replyByte0 = replyByte0_q;
  assign replyByte1 = replyByte1_q;
  assign accessOpen = accessOpen_q;
  assign tagActive  = tagActive_q;

  // checks, suspended while frozen
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !clkEn);

  AST_HALT_ACK: assert property (
    cmdTake && cmdOp == OP_HALT_REL |=> replyValid && replyByte1[3:0] == ACK_NIB
      && !tagActive && state_q == ST_IDLE)
    else $error("halt-release not acknowledged into halt");

  AST_HALT_NEVER_NACK: assert property (
    replyValid && replyByte0[7:4] == OP_HALT_REL |-> replyByte1[3:0] == ACK_NIB)
    else $error("halt-release answered with nack");

  AST_OPEN_AFTER_RESET: assert property (
    $fell(sys_rst) |-> !accessOpen ##1 (!accessOpen || $past(openSet)))
    else $error("access open after reset");

  AST_VERIFY_MATCH: assert property (
    state_q == ST_RD_PAGE && opcode_q == OP_VERIFY && memDone
      && cmdData_q == memRdData && cmdData_q != PWD_ALL_ONES
      |=> replyValid && replyByte1 == {ERR_NONE, ACK_NIB} && accessOpen)
    else $error("matching password not granted");

  AST_VERIFY_MISMATCH: assert property (
    state_q == ST_RD_PAGE && opcode_q == OP_VERIFY && memDone && cmdData_q != memRdData
      |=> replyValid && replyByte1 == {ERR_PASSWORD, NACK_NIB} && !accessOpen)
    else $error("wrong password not refused");

  AST_VERIFY_ONES: assert property (
    state_q == ST_RD_PAGE && opcode_q == OP_VERIFY && memDone && cmdData_q == PWD_ALL_ONES
      |=> replyValid && replyByte1[3:0] == NACK_NIB ##1 !accessOpen)
    else $error("all-ones password granted");

  AST_COUNT_CLOSED: assert property (
    cmdTake && cmdOp == OP_COUNT && !accessOpen
      |=> replyValid && replyByte1[3:0] == NACK_NIB && !memReq)
    else $error("counter update ran without access");

  AST_COUNT_LIMIT: assert property (
    state_q == ST_RD_PAGE && opcode_q == OP_COUNT && memDone && cntOld == COUNTER_LIMIT
      |=> replyValid && replyByte1 == {ERR_LIMIT, NACK_NIB} && !memReq)
    else $error("counter at limit was updated");

  AST_COUNT_WRITE: assert property (
    state_q == ST_RD_PAGE && opcode_q == OP_COUNT && memDone && cntOld != COUNTER_LIMIT
      |=> memReq && memWrite && memPage == PAGE_COUNTER
      && memWrData[COUNTER_LSB +: 16] == $past(cntOld) + COUNTER_STEP
      && memWrData[SIG_BITS-1:0] == cmdData_q[SIG_BITS-1:0])
    else $error("counter page written wrongly");

  AST_LOCK_PAGE0: assert property (
    cmdTake && cmdOp == OP_LOCK && accessOpen && idleLockReq == 32'h0000_0000
      |=> replyValid && replyByte1[3:0] == ACK_NIB && !memReq)
    else $error("page 0 lock not plainly acknowledged");

  // no reply may stand in any cycle of the write wait, the entry cycle included
  AST_ACK_AFTER_WRITE: assert property (
    state_q == ST_WRITE |-> !replyValid)
    else $error("acknowledge before write completed");

endmodule

/* verification/page_mem_model.sv */
`timescale 1ns/1ps
// nonvolatile page store behind the sequencer; no reset, contents survive power cycles
module page_mem_model
(
  // clock
  input  wire logic        clk,
  // extra answer delay, 0 = prompt
  input  wire logic [3:0]  latency,
  // request side
  input  wire logic        memReq,
  input  wire logic        memWrite,
  input  wire logic [4:0]  memPage,
  input  wire logic [63:0] memWrData,
  // answer side
  output logic [63:0]      memRdData,
  output logic             memDone
);
  logic [63:0] pages [32];
  logic [63:0] rdData_q;
  logic [63:0] wrData_q;
  logic [4:0]  page_q;
  logic        write_q;
  logic        busy_q;
  int          wait_q;

  // delivered blank, the password page included
  initial
  begin
    foreach (pages[i]) pages[i] = '0;
    memDone = 1'b0;
    busy_q = 1'b0;
    rdData_q = '0;
  end

  // one access at a time; done never comes on the request edge
  always @(posedge clk)
  begin
    memDone <= 1'b0;
    if (memReq)
    begin
      busy_q <= 1'b1;
      wait_q <= int'(latency);
      page_q <= memPage;
      write_q <= memWrite;
      wrData_q <= memWrData;
    end
    else if (busy_q)
    begin
      if (wait_q == 0)
      begin
        busy_q <= 1'b0;
        memDone <= 1'b1;
        rdData_q <= pages[page_q];
        if (write_q) pages[page_q] <= wrData_q;
      end
      else wait_q <= wait_q - 1;
    end
  end

  // data only means something with done; otherwise show the inverse so stale use shows up
  assign memRdData = memDone ? rdData_q : ~rdData_q;
endmodule

/* verification/rfid_tag_password_counter_cmds_test.sv */
`timescale 1ns/1ps
module rfid_tag_password_counter_cmds_test;
  import tag_cmd_pkg::*;
  logic        clk;
  logic        sys_rst;
  logic        clkEn;
  logic        cmdValid;
  logic [95:0] cmdFrame;
  logic        wakeActive;
  logic        memReq;
  logic        memWrite;
  logic [4:0]  memPage;
  logic [63:0] memWrData;
  logic [63:0] memRdData;
  logic        memDone;
  logic [3:0]  memLat;
  logic        replyValid;
  logic [7:0]  replyByte0;
  logic [7:0]  replyByte1;
  logic        accessOpen;
  logic        tagActive;
  // reference state of the tag
  logic        expOpen;
  logic [63:0] expPwd;
  logic [63:0] expPage2;
  logic [31:0] expLock;
  logic [31:0] serial;
  logic [63:0] newPwd;
  logic [3:0]  cid;
  logic        got;
  int          num_errors;
  int          n_compared;
  int          cycles;

  tag_cmd_exec u_dut (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .cmdValid(cmdValid),
    .cmdFrame(cmdFrame), .wakeActive(wakeActive), .memReq(memReq), .memWrite(memWrite),
    .memPage(memPage), .memWrData(memWrData), .memRdData(memRdData), .memDone(memDone),
    .replyValid(replyValid), .replyByte0(replyByte0), .replyByte1(replyByte1),
    .accessOpen(accessOpen), .tagActive(tagActive));

  page_mem_model u_mem (.clk(clk), .latency(memLat), .memReq(memReq), .memWrite(memWrite),
    .memPage(memPage), .memWrData(memWrData), .memRdData(memRdData), .memDone(memDone));

  always #20 clk = ~clk;

  task automatic chk_page(input string what, input logic [63:0] exp, input logic [63:0] seen);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_flag(input string what, input logic exp, input logic seen);
    chk_page(what, {63'h0, exp}, {63'h0, seen});
  endtask

  // ack: only the low nibble is promised; nack carries the error code on top
  task automatic chk_reply(input logic [3:0] op, input logic [3:0] err, input logic nack);
    chk_flag("replyValid", 1'b1, got);
    chk_page("replyByte0", {56'h0, op, cid}, {56'h0, replyByte0});
    if (nack) chk_page("replyByte1", {56'h0, err, NACK_NIB}, {56'h0, replyByte1});
    else chk_page("replyByte1", {60'h0, ACK_NIB}, {60'h0, replyByte1[3:0]});
  endtask

  // one frame, then wait a bounded time for the reply pulse
  task automatic send(input logic [3:0] op, input logic [63:0] d);
    int n;
    @(posedge clk);
    cid = 4'($urandom);
    cmdFrame <= {16'($urandom), d, 8'($urandom), op, cid};
    memLat <= 4'($urandom % 5);
    cmdValid <= 1'b1;
    @(posedge clk);
    cmdValid <= 1'b0;
    got = 1'b0;
    n = 0;
    while (!got && n < 80)
    begin
      #1;
      if (replyValid === 1'b1) got = 1'b1;
      else @(posedge clk);
      n++;
    end
  endtask

  task automatic do_verify(input logic [63:0] p);
    logic ok;
    ok = (p === expPwd) && (p !== PWD_ALL_ONES);
    expOpen = ok;
    send(OP_VERIFY, p);
    chk_reply(OP_VERIFY, ERR_PASSWORD, !ok);
    chk_flag("accessOpen", expOpen, accessOpen);
  endtask

  task automatic do_count(input logic [63:0] d);
    logic [3:0]  err;
    logic [15:0] cnt;
    cnt = expPage2[63:48];
    err = !expOpen ? ERR_PASSWORD : expLock[2] ? ERR_LOCKED
        : (cnt == COUNTER_LIMIT) ? ERR_LIMIT : ERR_NONE;
    if (err == ERR_NONE) expPage2 = {cnt + 16'h0001, d[47:0]};
    send(OP_COUNT, d);
    chk_reply(OP_COUNT, err, err != ERR_NONE);
    chk_page("page2", expPage2, u_mem.pages[2]);
  endtask

  task automatic do_lock(input logic [31:0] mask);
    if (expOpen) expLock = expLock | (mask & 32'hFFFF_FFFE);
    send(OP_LOCK, {mask, 32'($urandom)});
    chk_reply(OP_LOCK, ERR_PASSWORD, !expOpen);
    chk_page("page0", {expLock, serial}, u_mem.pages[0]);
  endtask

  task give_verdict;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the sequence needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      $display("ERROR cycles expected below 20000 seen %0d", cycles);
      give_verdict;
    end
  end

  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    clkEn = 1'b1;
    cmdValid = 1'b0;
    cmdFrame = '0;
    wakeActive = 1'b0;
    memLat = 4'h0;
    num_errors = 0;
    n_compared = 0;
    cycles = 0;
    void'($urandom(26836));
    repeat (5) @(posedge clk);
    serial = $urandom;
    expLock = 32'h0;
    expPwd = 64'h0;
    expPage2 = {16'h0005, 48'h0};
    u_mem.pages[0] = {expLock, serial};
    u_mem.pages[2] = expPage2;
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk_flag("accessOpen", 1'b0, accessOpen);
    chk_flag("tagActive", 1'b0, tagActive);
    @(posedge clk);
    wakeActive <= 1'b1;
    @(posedge clk);
    wakeActive <= 1'b0;
    @(posedge clk);
    #1;
    chk_flag("tagActive", 1'b1, tagActive);
    // unhandled opcode is dropped silently
    send(4'h4, 64'h0);
    chk_flag("replyValid", 1'b0, got);
    // closed: protected commands refused
    do_count({$urandom, $urandom});
    do_lock(32'h0000_0004);
    do_verify(64'h0);
    do_verify(expPwd ^ (64'h1 << ($urandom % 64)));
    do_count({$urandom, $urandom});
    do_verify(64'h0);
    repeat (3) do_count({$urandom, $urandom});
    // last step into the limit is allowed, then page 2 is frozen
    expPage2[63:48] = 16'h7FFF;
    u_mem.pages[2] = expPage2;
    do_count({$urandom, $urandom});
    do_count({$urandom, $urandom});
    expPage2[63:48] = 16'h0010;
    u_mem.pages[2] = expPage2;
    do_lock(32'h0000_0001);
    do_lock($urandom | 32'h0000_0005);
    do_count({$urandom, $urandom});
    // reader rewrites the password page while open
    newPwd = {$urandom, $urandom};
    u_mem.pages[3] = newPwd;
    expPwd = newPwd;
    chk_flag("accessOpen", 1'b1, accessOpen);
    do_verify(newPwd);
    do_verify(PWD_ALL_ONES);
    u_mem.pages[3] = PWD_ALL_ONES;
    expPwd = PWD_ALL_ONES;
    do_verify(PWD_ALL_ONES);
    u_mem.pages[3] = newPwd;
    expPwd = newPwd;
    do_verify(newPwd);
    send(OP_HALT_REL, {$urandom, $urandom});
    chk_reply(OP_HALT_REL, ERR_NONE, 1'b0);
    chk_flag("tagActive", 1'b0, tagActive);
    // a frozen tag must ignore a wake while the enable is low
    @(posedge clk);
    clkEn <= 1'b0;
    wakeActive <= 1'b1;
    repeat (2) @(posedge clk);
    clkEn <= 1'b1;
    wakeActive <= 1'b0;
    #1;
    chk_flag("tagActive", 1'b0, tagActive);
    send(OP_VERIFY, newPwd);
    chk_flag("replyValid", 1'b0, got);
    // second power-up closes access again
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk_flag("accessOpen", 1'b0, accessOpen);
    give_verdict;
  end
endmodule
